// >>> rtl/vsync_field_pkg.sv
// Package with register map, field layout, reset values and reference lines for sync placement.
package vsync_field_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int LINE_W = 10;
    localparam int POS_W  = 5;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_VSYNC_FIELD_CONTROL_ONE   = 8'h31;
    localparam logic [7:0] OFS_VSYNC_FIELD_CONTROL_TWO   = 8'h32;
    localparam logic [7:0] OFS_VSYNC_FIELD_CONTROL_THREE = 8'h33;
    localparam logic [7:0] OFS_SYNC_PIN_POLARITY         = 8'h37;
    localparam logic [7:0] OFS_NTSC_VSYNC_END_CTRL       = 8'he6;
    localparam logic [7:0] OFS_NTSC_FIELD_TOGGLE_CTRL    = 8'he7;
    localparam logic [7:0] OFS_PAL_VSYNC_BEGIN_CTRL      = 8'he8;
    localparam logic [7:0] OFS_PAL_VSYNC_END_CTRL        = 8'he9;
    localparam logic [7:0] OFS_PAL_FIELD_TOGGLE_CTRL     = 8'hea;
    localparam logic [7:0] OFS_SYNC_STATUS               = 8'heb;

    // ************************************************************
    // Field layout shared by every position register
    // ************************************************************
    localparam int BIT_ODD_DELAY  = 7;
    localparam int BIT_EVEN_DELAY = 6;
    localparam int BIT_DIRECTION  = 5;
    localparam int POS_LSB        = 0;

    // Status register bit positions.
    localparam int STAT_VS    = 0;
    localparam int STAT_FIELD = 1;
    localparam int STAT_PAL   = 2;
    localparam int STAT_ODD   = 3;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RST_CONTROL_ONE        = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO        = 8'h00;
    localparam logic [7:0] RST_CONTROL_THREE      = 8'h00;
    localparam logic [7:0] RST_POLARITY           = 8'h00;
    localparam logic [7:0] RST_NTSC_VSYNC_END     = 8'h04;
    localparam logic [7:0] RST_NTSC_FIELD_TOGGLE  = 8'h63;
    localparam logic [7:0] RST_PAL_VSYNC_BEGIN    = 8'h65;
    localparam logic [7:0] RST_PAL_VSYNC_END      = 8'h14;
    localparam logic [7:0] RST_PAL_FIELD_TOGGLE   = 8'h63;

    // ************************************************************
    // Reference lines, counted from the first line of a field
    // ************************************************************
    localparam logic [LINE_W-1:0] REF_NTSC_VS_START = 10'd3;
    localparam logic [LINE_W-1:0] REF_NTSC_VS_END   = 10'd32;
    localparam logic [LINE_W-1:0] REF_NTSC_TOGGLE   = 10'd32;
    localparam logic [LINE_W-1:0] REF_PAL_VS_START  = 10'd32;
    localparam logic [LINE_W-1:0] REF_PAL_VS_END    = 10'd32;
    localparam logic [LINE_W-1:0] REF_PAL_TOGGLE    = 10'd32;

endpackage

// >>> rtl/line_timing_if.sv
// Interface carrying the line count and field parity from the sequencer to position matchers.
interface line_timing_if;
    logic                                line_start;
    logic                                field_start;
    logic [vsync_field_pkg::LINE_W-1:0]  line_count;
    logic                                field_odd;

    modport source (output line_start, output field_start, output line_count, output field_odd);
    modport sink   (input line_start, input field_start, input line_count, input field_odd);
endinterface

// >>> rtl/line_position_match.sv
// Matcher that turns one position setting into a one-line event pulse.
module line_position_match #(
    parameter logic [vsync_field_pkg::LINE_W-1:0] REF_LINE = 10'd32
) (
    // Timing from the sequencer
    line_timing_if.sink timing,
    // Setting latched for the current field
    input  wire logic [7:0] ctrl,
    // Event pulse on the matching line start
    output logic            hit
);

    // Target line: reference moved by position, sign selects direction.
    function automatic logic [vsync_field_pkg::LINE_W-1:0] target_line(
        input logic [vsync_field_pkg::LINE_W-1:0] ref_line,
        input logic [7:0]                         setting,
        input logic                               odd
    );
        logic [vsync_field_pkg::LINE_W-1:0] pos;
        logic [vsync_field_pkg::LINE_W-1:0] base;
        logic                               extra;
        pos   = {5'h00, setting[vsync_field_pkg::POS_LSB +: vsync_field_pkg::POS_W]};
        extra = odd ? setting[vsync_field_pkg::BIT_ODD_DELAY]
                    : setting[vsync_field_pkg::BIT_EVEN_DELAY];
        if (setting[vsync_field_pkg::BIT_DIRECTION]) begin
            base = ref_line - pos;
        end else begin
            base = ref_line + pos;
        end
        return base + {9'h000, extra};
    endfunction

    logic [vsync_field_pkg::LINE_W-1:0] target;

    // Field parity picks which one-line delay bit applies.
    assign target = target_line(REF_LINE, ctrl, timing.field_odd);
    // The first line of a field restarts the count, so it never matches.
    assign hit = timing.line_start && !timing.field_start && (timing.line_count == target);

endmodule

// >>> rtl/vsync_field_position_control.sv
// Vertical sync and field toggle placement for embedded timing codes and sync pins.

// Functional notes
// - NTSC sync end position, five bits, reset 00100.
// - Sync settings move code flag and pin together.
// - NTSC odd delay bit adds one line.
// - NTSC even delay bit adds one line.
// - NTSC toggle sign: one advances, zero delays.
// - NTSC toggle position, five bits, reset 00011.
// - Field settings move code flag and pin.
// - PAL start odd delay adds one line.
// - PAL start even delay adds one line.
// - PAL start sign: one advances, zero delays.
// - PAL start position, five bits, reset 00101.
// - PAL stop odd delay adds one line.
// - PAL stop even delay adds one line.
// - PAL stop sign: zero delays, one advances.
// - PAL stop position, five bits, reset 10100.
// - PAL toggle odd delay adds one line.
// - PAL toggle even delay adds one line.
// - PAL toggle sign: one advances, zero delays.
// - PAL toggle position, five bits, reset 00011.
module vsync_field_position_control (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Raw timing from the video timing generator
    input  wire logic       line_start,
    input  wire logic       field_start,
    input  wire logic       field_odd_in,
    input  wire logic       pal_mode,
    // Flags for the embedded timing codes
    output logic            v_bit,
    output logic            f_bit,
    // Sync pins toward the downstream receiver
    output logic            vertical_sync_pin,
    output logic            field_or_data_enable_pin
);

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] vsync_field_control_one;
    logic [7:0] vsync_field_control_two;
    logic [7:0] vsync_field_control_three;
    logic [7:0] sync_pin_polarity;
    logic [7:0] ntsc_vsync_end_ctrl;
    logic [7:0] ntsc_field_toggle_ctrl;
    logic [7:0] pal_vsync_begin_ctrl;
    logic [7:0] pal_vsync_end_ctrl;
    logic [7:0] pal_field_toggle_ctrl;

    // Copies used by the placement logic for the field in progress.
    logic [7:0] shadow_ntsc_end;
    logic [7:0] shadow_ntsc_toggle;
    logic [7:0] shadow_pal_start;
    logic [7:0] shadow_pal_stop;
    logic [7:0] shadow_pal_toggle;
    logic       shadow_pal;

    // Sequencer state.
    logic [vsync_field_pkg::LINE_W-1:0] line_count;
    logic                               field_odd;

    // Sync state, one flop each, feeding both code flags and pins.
    logic vs_level;
    logic field_level;

    // Event pulses from the matchers.
    logic hit_ntsc_end;
    logic hit_ntsc_toggle;
    logic hit_pal_start;
    logic hit_pal_stop;
    logic hit_pal_toggle;
    logic hit_ntsc_start;

    // Combined events for the active standard.
    logic vs_rise;
    logic vs_fall;
    logic toggle_now;

    // Next values of the sync state.
    logic next_vs_level;
    logic next_field_level;

    // Read data selected from the address.
    logic [7:0] next_rdata;

    // Readable status.
    logic [7:0] sync_status;

    line_timing_if timing ();

    // ************************************************************
    // Register writes
    // ************************************************************

    // Writes land in the live copies at once; the placement logic only
    // sees them at the next field boundary, so a write mid-field cannot
    // cut a sync pulse short or produce a double edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vsync_field_control_one   <= vsync_field_pkg::RST_CONTROL_ONE;
            vsync_field_control_two   <= vsync_field_pkg::RST_CONTROL_TWO;
            vsync_field_control_three <= vsync_field_pkg::RST_CONTROL_THREE;
            sync_pin_polarity         <= vsync_field_pkg::RST_POLARITY;
            ntsc_vsync_end_ctrl       <= vsync_field_pkg::RST_NTSC_VSYNC_END;
            ntsc_field_toggle_ctrl    <= vsync_field_pkg::RST_NTSC_FIELD_TOGGLE;
            pal_vsync_begin_ctrl      <= vsync_field_pkg::RST_PAL_VSYNC_BEGIN;
            pal_vsync_end_ctrl        <= vsync_field_pkg::RST_PAL_VSYNC_END;
            pal_field_toggle_ctrl     <= vsync_field_pkg::RST_PAL_FIELD_TOGGLE;
        end else if (reg_wr) begin
            if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_ONE) begin
                vsync_field_control_one <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_TWO) begin
                vsync_field_control_two <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_THREE) begin
                vsync_field_control_three <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_SYNC_PIN_POLARITY) begin
                sync_pin_polarity <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_NTSC_VSYNC_END_CTRL) begin
                ntsc_vsync_end_ctrl <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_NTSC_FIELD_TOGGLE_CTRL) begin
                ntsc_field_toggle_ctrl <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_PAL_VSYNC_BEGIN_CTRL) begin
                pal_vsync_begin_ctrl <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_PAL_VSYNC_END_CTRL) begin
                pal_vsync_end_ctrl <= reg_wdata;
            end else if (reg_addr == vsync_field_pkg::OFS_PAL_FIELD_TOGGLE_CTRL) begin
                pal_field_toggle_ctrl <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************

    // Status shows the live sync state so software can poll for the
    // vertical interval before touching the placement registers.
    always_comb begin
        sync_status = 8'h00;
        sync_status[vsync_field_pkg::STAT_VS]    = vs_level;
        sync_status[vsync_field_pkg::STAT_FIELD] = field_level;
        sync_status[vsync_field_pkg::STAT_PAL]   = shadow_pal;
        sync_status[vsync_field_pkg::STAT_ODD]   = field_odd;
    end

    // Address decode for reads; unmapped addresses answer zero.
    always_comb begin
        if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_ONE) begin
            next_rdata = vsync_field_control_one;
        end else if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_TWO) begin
            next_rdata = vsync_field_control_two;
        end else if (reg_addr == vsync_field_pkg::OFS_VSYNC_FIELD_CONTROL_THREE) begin
            next_rdata = vsync_field_control_three;
        end else if (reg_addr == vsync_field_pkg::OFS_SYNC_PIN_POLARITY) begin
            next_rdata = sync_pin_polarity;
        end else if (reg_addr == vsync_field_pkg::OFS_NTSC_VSYNC_END_CTRL) begin
            next_rdata = ntsc_vsync_end_ctrl;
        end else if (reg_addr == vsync_field_pkg::OFS_NTSC_FIELD_TOGGLE_CTRL) begin
            next_rdata = ntsc_field_toggle_ctrl;
        end else if (reg_addr == vsync_field_pkg::OFS_PAL_VSYNC_BEGIN_CTRL) begin
            next_rdata = pal_vsync_begin_ctrl;
        end else if (reg_addr == vsync_field_pkg::OFS_PAL_VSYNC_END_CTRL) begin
            next_rdata = pal_vsync_end_ctrl;
        end else if (reg_addr == vsync_field_pkg::OFS_PAL_FIELD_TOGGLE_CTRL) begin
            next_rdata = pal_field_toggle_ctrl;
        end else if (reg_addr == vsync_field_pkg::OFS_SYNC_STATUS) begin
            next_rdata = sync_status;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Read data is registered and holds until the next read strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Field boundary latch
    // ************************************************************

    // Every setting and the standard are captured together at the field
    // boundary, so one field is always placed from one consistent set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_ntsc_end    <= vsync_field_pkg::RST_NTSC_VSYNC_END;
            shadow_ntsc_toggle <= vsync_field_pkg::RST_NTSC_FIELD_TOGGLE;
            shadow_pal_start   <= vsync_field_pkg::RST_PAL_VSYNC_BEGIN;
            shadow_pal_stop    <= vsync_field_pkg::RST_PAL_VSYNC_END;
            shadow_pal_toggle  <= vsync_field_pkg::RST_PAL_FIELD_TOGGLE;
            shadow_pal         <= 1'b0;
            field_odd          <= 1'b1;
        end else if (field_start) begin
            shadow_ntsc_end    <= ntsc_vsync_end_ctrl;
            shadow_ntsc_toggle <= ntsc_field_toggle_ctrl;
            shadow_pal_start   <= pal_vsync_begin_ctrl;
            shadow_pal_stop    <= pal_vsync_end_ctrl;
            shadow_pal_toggle  <= pal_field_toggle_ctrl;
            shadow_pal         <= pal_mode;
            field_odd          <= field_odd_in;
        end
    end

    // ************************************************************
    // Line sequencer
    // ************************************************************

    // Lines are counted from zero at the field boundary; the count
    // saturates so a missing boundary cannot wrap into false matches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_count <= '0;
        end else if (field_start) begin
            line_count <= '0;
        end else if (line_start && (line_count != '1)) begin
            line_count <= line_count + 10'd1;
        end
    end

    // Matchers see the count before it advances on the same line start.
    assign timing.line_start  = line_start;
    assign timing.field_start = field_start;
    assign timing.line_count  = line_count;
    assign timing.field_odd   = field_odd;

    // ************************************************************
    // Position matchers
    // ************************************************************

    // NTSC sync end from its five-bit position, sign and field delays.
    line_position_match #(
        .REF_LINE (vsync_field_pkg::REF_NTSC_VS_END)
    ) u_ntsc_end (
        .timing (timing),
        .ctrl   (shadow_ntsc_end),
        .hit    (hit_ntsc_end)
    );

    // NTSC field toggle; odd and even delay and sign come from bits 7..5.
    line_position_match #(
        .REF_LINE (vsync_field_pkg::REF_NTSC_TOGGLE)
    ) u_ntsc_toggle (
        .timing (timing),
        .ctrl   (shadow_ntsc_toggle),
        .hit    (hit_ntsc_toggle)
    );

    // PAL sync start.
    line_position_match #(
        .REF_LINE (vsync_field_pkg::REF_PAL_VS_START)
    ) u_pal_start (
        .timing (timing),
        .ctrl   (shadow_pal_start),
        .hit    (hit_pal_start)
    );

    // PAL sync stop; sign zero delays, one advances.
    line_position_match #(
        .REF_LINE (vsync_field_pkg::REF_PAL_VS_END)
    ) u_pal_stop (
        .timing (timing),
        .ctrl   (shadow_pal_stop),
        .hit    (hit_pal_stop)
    );

    // PAL field toggle.
    line_position_match #(
        .REF_LINE (vsync_field_pkg::REF_PAL_TOGGLE)
    ) u_pal_toggle (
        .timing (timing),
        .ctrl   (shadow_pal_toggle),
        .hit    (hit_pal_toggle)
    );

    // The NTSC start is not programmable here and sits at a fixed line.
    assign hit_ntsc_start = line_start && !field_start
                            && (line_count == vsync_field_pkg::REF_NTSC_VS_START);

    // ************************************************************
    // Event selection
    // ************************************************************

    // Only the events of the standard latched for this field act.
    always_comb begin
        if (shadow_pal) begin
            vs_rise    = hit_pal_start;
            vs_fall    = hit_pal_stop;
            toggle_now = hit_pal_toggle;
        end else begin
            vs_rise    = hit_ntsc_start;
            vs_fall    = hit_ntsc_end;
            toggle_now = hit_ntsc_toggle;
        end
    end

    // Sync state. If start and end fall on one line, end wins so that a
    // bad setting yields no pulse rather than one stuck high all field.
    always_comb begin
        next_vs_level = vs_level;
        if (vs_fall) begin
            next_vs_level = 1'b0;
        end else if (vs_rise) begin
            next_vs_level = 1'b1;
        end
    end

    // Field flag goes low for an odd field and high for an even one.
    always_comb begin
        next_field_level = field_level;
        if (toggle_now) begin
            next_field_level = !field_odd;
        end
    end

    // ************************************************************
    // Sync state flops
    // ************************************************************

    // One flop per flag keeps code flags and pins edge-aligned.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vs_level    <= 1'b0;
            field_level <= 1'b0;
        end else begin
            vs_level    <= next_vs_level;
            field_level <= next_field_level;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Code flag and pin share one flop, so they can never disagree.
    assign v_bit                    = vs_level;
    assign vertical_sync_pin        = vs_level;
    assign f_bit                    = field_level;
    assign field_or_data_enable_pin = field_level;

endmodule

// >>> bench/vsync_field_chk.sv
// Checker of flag timing and register readback at the block's ports.
module vsync_field_chk (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Timing and flags
    input wire logic       line_start,
    input wire logic       field_start,
    input wire logic       v_bit,
    input wire logic       f_bit,
    input wire logic       vertical_sync_pin,
    input wire logic       field_or_data_enable_pin
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Pins and code flags share one flop each, so a split means a wiring slip.
    chk_vs_pin_same: assert property (vertical_sync_pin == v_bit)
        else $error("sync pin differs from code flag");
    chk_field_pin_same: assert property (field_or_data_enable_pin == f_bit)
        else $error("field pin differs from code flag");
    chk_v_on_line: assert property ($changed(v_bit) |-> $past(line_start))
        else $error("sync flag moved off a line start");
    chk_f_on_line: assert property ($changed(f_bit) |-> $past(line_start))
        else $error("field flag moved off a line start");
    chk_field_line_quiet: assert property (field_start |=> $stable(v_bit) && $stable(f_bit))
        else $error("flag moved on the first line of a field");
    chk_end_readback: assert property ((reg_wr && !reg_rd && reg_addr == 8'he6) ##2
        (reg_rd && reg_addr == 8'he6) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("sync end setting not read back");
    chk_status_vs: assert property (reg_rd && reg_addr == 8'heb |=> reg_rdata[0] == $past(v_bit))
        else $error("status sync bit wrong");
    chk_status_field: assert property (reg_rd && reg_addr == 8'heb |=> reg_rdata[1] == $past(f_bit))
        else $error("status field bit wrong");
endmodule

bind vsync_field_position_control vsync_field_chk u_vsync_field_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_start(line_start), .field_start(field_start),
    .v_bit(v_bit), .f_bit(f_bit), .vertical_sync_pin(vertical_sync_pin),
    .field_or_data_enable_pin(field_or_data_enable_pin));

// >>> bench/video_sink_model.sv
// Model of the far side: line timing source and receiver that logs flag lines.
module video_sink_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bench control and flags from the block
    input  wire logic       run,
    input  wire logic       v_bit,
    input  wire logic       f_bit,
    // Line timing toward the block
    output logic            line_start,
    output logic            field_start,
    // Line index of each flag change in the last field
    output logic [7:0]      rvr,
    output logic [7:0]      rvf,
    output logic [7:0]      rft
);
    logic [1:0] ph;
    logic [7:0] idx, vr, vf, ft;
    logic       pv, pf;
    // Lines three clocks apart, sixty per field: room for the latest target line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ph, line_start, field_start, pv, pf} <= '0;
            idx <= 8'd59;
            {vr, vf, ft, rvr, rvf, rft} <= '0;
        end else begin
            {pv, pf} <= {v_bit, f_bit};
            line_start <= run && ph == 2'd2;
            field_start <= run && ph == 2'd2 && idx == 8'd59;
            ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
            if (run && ph == 2'd2) idx <= (idx == 8'd59) ? 8'd0 : idx + 8'd1;
            // Clearing at each capture makes a missing event read as ff, not stale.
            if (run && ph == 2'd2 && idx == 8'd59) begin
                {rvr, rvf, rft} <= {vr, vf, ft};
                {vr, vf, ft}    <= '1;
            end
            if (v_bit && !pv) vr <= idx;
            if (!v_bit && pv) vf <= idx;
            if (f_bit != pf) ft <= idx;
        end
    end
endmodule

// >>> bench/vsync_field_position_control_bench.sv
// Testbench: register access and six fields of sync placement.
module vsync_field_position_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rvr, rvf, rft;
    logic       pal_mode = 1'b0, field_odd_in = 1'b0, line_start, field_start;
    logic       v_bit, f_bit, vertical_sync_pin, field_or_data_enable_pin;
    int         miscompares = 0, n_tests = 0, i, j;
    // Settings for 0xe7..0xea per field, then expected rise, fall and toggle line.
    logic [31:0] cfg [6] = '{32'h63651463, 32'h85651463, 32'h85651463,
                             32'h85010406, 32'h85214446, 32'h85bfaa86};
    logic [23:0] ev [6] = '{24'h04251f, 24'h042527, 24'h1d351f,
                            24'h222527, 24'h202628, 24'h031828};
    logic [7:0]  rstv [5] = '{8'h04, 8'h63, 8'h65, 8'h14, 8'h63};
    always #20 clk = ~clk;
    vsync_field_position_control u_vsync_field_position_control (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_start(line_start), .field_start(field_start),
        .field_odd_in(field_odd_in), .pal_mode(pal_mode), .v_bit(v_bit), .f_bit(f_bit),
        .vertical_sync_pin(vertical_sync_pin),
        .field_or_data_enable_pin(field_or_data_enable_pin));
    video_sink_model u_video_sink_model (.clk(clk), .rst_n(rst_n), .run(run), .v_bit(v_bit),
        .f_bit(f_bit), .line_start(line_start), .field_start(field_start), .rvr(rvr),
        .rvf(rvf), .rft(rft));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes last one cycle, then an idle edge passes, so a second call never
    // raises a strobe in the same step that lowered it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge clk) #1 reg_wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [7:0] a);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge clk) #1 reg_rd = 1'b0;
        @(posedge clk) #1;
    endtask
    // Returns one edge after the pulse is seen, after the latch; settings written next apply from the following field.
    task automatic wait_fs();
        do begin
            @(posedge clk) #1;
        end while (field_start !== 1'b1);
        @(posedge clk) #1;
    endtask
    task automatic complete_run();
        $display("%0d comparisons, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(8'he6 + i[7:0]);
            check(reg_rdata, rstv[i]);
        end
        rd(8'h00);
        check(reg_rdata, 8'h00);
        wr(8'he6, 8'h1f);
        rd(8'he6);
        check(reg_rdata, 8'h1f);
        wr(8'he6, 8'h04);
        wr(8'h37, 8'h29);
        rd(8'h37);
        check(reg_rdata, 8'h29);
        $display("register test done");
        run = 1'b1;
        for (i = 0; i <= 6; i++) begin
            wait_fs();
            if (i > 0) begin
                check(rvr, ev[i-1][23:16]);
                check(rvf, ev[i-1][15:8]);
                check(rft, ev[i-1][7:0]);
                $display("field test %0d done", i - 1);
            end
            if (i < 5) begin
                {pal_mode, field_odd_in} = {i >= 1, ~i[0]};
                for (j = 0; j < 4; j++) wr(8'he7 + j[7:0], cfg[i+1][31-8*j -: 8]);
                rd(8'heb);
                check(reg_rdata, {4'h0, i[0], i >= 2, i[0], 1'b0});
            end
        end
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule
